// *** logic/vms_cfg.svh ***
// Register offsets, field positions, reset values and timing constants
`ifndef VMS_CFG_SVH
`define VMS_CFG_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CONFIG 12'h000
`define OFS_POWER_DOWN 12'h004
`define OFS_STEP_INTERVAL 12'h008
`define OFS_QUIET_PWM 12'h00c
`define OFS_LOAD_ADAPT 12'h010
`define OFS_HIGH_SPEED 12'h014
`define OFS_STATUS 12'h018
`define OFS_CHOPPER 12'h01c
// ----------------------------------------------------------------
// Config bit positions
// ----------------------------------------------------------------
`define CFG_SMALL_HYST 0
`define CFG_HS_FULLSTEP 1
`define CFG_HS_CHOPPER 2
`define CFG_EN_PWM 3
`define CFG_EXT_STEP 4
// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define POWER_DOWN_RESET 8'h0a
`define HIGH_SPEED_RESET 20'h00000
`define STST_LOG2 20
`define PD_STEP_LOG2 18
`define INTERVAL_MAX 20'hfffff
`define STATUS_W 13
`endif

// *** logic/vms_pkg.sv ***
// Types shared by the velocity mode selector
package vms_pkg;
    typedef struct packed {
        logic small_hyst;
        logic hs_fullstep;
        logic hs_chopper;
        logic en_pwm;
        logic ext_step;
    } vms_cfg_t;
    typedef struct packed {
        logic pwm_chop;
        logic velocity_step;
        logic stall_detect;
        logic load_adapt;
        logic stall_out;
        logic chopper_sync;
        logic fullstep;
        logic chopper_mode;
        logic fast_decay_zero;
        logic off_time_double;
    } vms_mode_t;
endpackage

// *** logic/step_interval_meter.sv ***
// Step interval measurement with standstill detection
`timescale 1ns/1ps
`default_nettype none
`include "vms_cfg.svh"
module step_interval_meter import vms_pkg::*; #(
    parameter int W = 20,
    parameter int STST_CYCLES = 1 << `STST_LOG2
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Step pulse and weight in 1/256 units
    input wire logic step,
    input wire logic [8:0] weight,
    // Results
    output logic [W-1:0] interval,
    output logic standstill
);
    initial if (W != 20 || STST_CYCLES < 2 || STST_CYCLES > (1 << W))
        $error("step_interval_meter parameters unsupported");
    localparam logic [W-1:0] IDLE_LAST = W'(STST_CYCLES - 1);
    logic [W:0] count;
    logic [W-1:0] idle;
    wire logic [W:0] scaled = count / {{(W-8){1'b0}}, weight};
    wire logic idle_done = idle == IDLE_LAST;
    wire logic sat = scaled[W] | idle_done;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
            idle <= '0;
            interval <= '0;
            standstill <= 1'b0;
        end else if (step) begin
            count <= {{W{1'b0}}, 1'b1};
            idle <= '0;
            standstill <= 1'b0;
            interval <= sat ? `INTERVAL_MAX : scaled[W-1:0];
        end else begin
            count <= count[W] ? count : count + 1'b1;
            idle <= idle_done ? idle : idle + 1'b1;
            if (idle_done) begin
                standstill <= 1'b1;
                interval <= `INTERVAL_MAX;
            end
        end
    end
endmodule // step_interval_meter
`default_nettype wire

// *** logic/threshold_hyst.sv ***
// Threshold comparison with hysteresis
`timescale 1ns/1ps
`default_nettype none
module threshold_hyst #(
    parameter int W = 20
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Operands
    input wire logic [W-1:0] interval,
    input wire logic [W-1:0] threshold,
    input wire logic small_hyst,
    // Result: interval at or below threshold
    output logic fast
);
    initial if (W < 6) $error("threshold_hyst width too small");
    wire logic [W-1:0] hyst = small_hyst ? (interval >> 5) : (interval >> 4);
    wire logic [W-1:0] upper = interval - hyst - 1'b1;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) fast <= 1'b0;
        else if (!fast && interval <= threshold) fast <= 1'b1;
        else if (fast && upper >= threshold && interval > threshold)
            fast <= 1'b0;
    end
endmodule // threshold_hyst
`default_nettype wire

// *** logic/velocity_mode_selector.sv ***
// Velocity based mode selector with APB registers
// Summary of operation
// - Standstill flag sets 2^20 clocks after last step; resets to zero.
// - Standstill selects hold current, otherwise run current.
// - Power-down follows standstill after 0, 1 or n*2^18 clocks.
// - Interval measured in clocks, normalised to 1/256 microsteps.
// - Interval saturates at 1048575 on overflow or standstill; reset 0.
// - Hysteresis of 1/16 or 1/32 on every threshold comparison.
// - Lower switch uses raw interval, upper uses 15/16 or 31/32 minus one.
// - Interval above quiet threshold allows PWM, stops velocity step.
// - Between high and load-adapt thresholds: stall detect, adapt, no PWM.
// - Interval at most load-adapt threshold enables stall output.
// - At or under high threshold: no adapt, no PWM, sync forced off.
// - High-speed chopper: mode 1, fast decay 0, off time doubled, capped at 15.
// - High-speed full step: full-step mode only; velocity step still follows quiet threshold.
// - Full step entered and left only at the 45 degree position.
// - Full-step and chopper high-speed bits may be active together.
// - PWM enable turns on only at standstill; runs above quiet threshold.
// - Internal generator interval derives from its 1/256 step rate.
`timescale 1ns/1ps
`default_nettype none
`include "vms_cfg.svh"
module velocity_mode_selector import vms_pkg::*; #(
    parameter int W = 20,
    parameter int STST_CYCLES = 1 << `STST_LOG2,
    parameter int PD_UNIT = 1 << `PD_STEP_LOG2
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Step sources
    input wire logic int_step,
    input wire logic ext_step_pin,
    input wire logic [8:0] ustep_weight,
    // Position at 45 degrees
    input wire logic at_45deg,
    // Chopper setting
    input wire logic [3:0] off_time,
    // Mode outputs
    output vms_mode_t mode,
    output logic [3:0] off_time_eff,
    output logic hold_current,
    output logic power_down,
    output logic standstill
);
    initial if (W != 20 || STST_CYCLES < 2 || PD_UNIT < 2)
        $error("velocity_mode_selector parameters unsupported");
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    vms_cfg_t cfg;
    logic [7:0] power_down_delay;
    logic [W-1:0] quiet_pwm_threshold;
    logic [W-1:0] load_adapt_threshold;
    logic [W-1:0] high_speed_threshold;
    logic pwm_on;
    logic ext_s1, ext_s2, ext_s3;
    logic [W-1:0] step_interval;
    logic stst_raw;
    logic fast_high, fast_load, fast_quiet;
    logic [27:0] pd_count;
    // ----------------------------------------------------------------
    // External step synchroniser and source select
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
        end else begin
            ext_s1 <= ext_step_pin;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
        end
    end
    wire logic ext_edge = ext_s2 & ~ext_s3;
    wire logic step = cfg.ext_step ? ext_edge : int_step;
    // ----------------------------------------------------------------
    // Measurement and comparisons
    // ----------------------------------------------------------------
    step_interval_meter #(
        .W(W),
        .STST_CYCLES(STST_CYCLES)
    ) u_meter (
        .pclk(pclk),
        .presetn(presetn),
        .step(step),
        .weight(ustep_weight),
        .interval(step_interval),
        .standstill(stst_raw)
    );
    threshold_hyst #(.W(W)) u_high (
        .pclk(pclk), .presetn(presetn), .interval(step_interval),
        .threshold(high_speed_threshold), .small_hyst(cfg.small_hyst),
        .fast(fast_high)
    );
    threshold_hyst #(.W(W)) u_load (
        .pclk(pclk), .presetn(presetn), .interval(step_interval),
        .threshold(load_adapt_threshold), .small_hyst(cfg.small_hyst),
        .fast(fast_load)
    );
    threshold_hyst #(.W(W)) u_quiet (
        .pclk(pclk), .presetn(presetn), .interval(step_interval),
        .threshold(quiet_pwm_threshold), .small_hyst(cfg.small_hyst),
        .fast(fast_quiet)
    );
    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------
    wire logic quiet_zone = !fast_quiet || stst_raw;
    wire logic mid_zone = fast_load && !fast_high;
    wire logic hs_fs_req = fast_high && cfg.hs_fullstep;
    vms_mode_t next_mode;
    always_comb begin
        next_mode = '0;
        next_mode.pwm_chop = pwm_on && quiet_zone && !fast_load
            && !fast_high;
        next_mode.velocity_step = !quiet_zone;
        next_mode.stall_detect = mid_zone;
        next_mode.load_adapt = mid_zone;
        next_mode.stall_out = fast_load;
        next_mode.chopper_sync = !fast_high;
        next_mode.fullstep = (hs_fs_req == mode.fullstep || at_45deg)
            ? hs_fs_req : mode.fullstep;
        next_mode.chopper_mode = fast_high && cfg.hs_chopper;
        next_mode.fast_decay_zero = fast_high && cfg.hs_chopper;
        next_mode.off_time_double = fast_high && cfg.hs_chopper;
    end
    wire logic [3:0] next_off = next_mode.off_time_double
        ? ((off_time > 4'h7) ? 4'hf : {off_time[2:0], 1'b0}) : off_time;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= '0;
            off_time_eff <= '0;
        end else begin
            mode <= next_mode;
            off_time_eff <= next_off;
        end
    end
    // ----------------------------------------------------------------
    // Standstill, hold current and power-down delay
    // ----------------------------------------------------------------
    wire logic [27:0] pd_target = (power_down_delay <= 8'h01)
        ? {20'h00000, power_down_delay}
        : 28'(power_down_delay) * 28'(PD_UNIT);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pd_count <= '0;
            power_down <= 1'b0;
            standstill <= 1'b0;
            hold_current <= 1'b0;
        end else begin
            standstill <= stst_raw;
            hold_current <= stst_raw;
            if (!stst_raw) begin
                pd_count <= '0;
                power_down <= 1'b0;
            end else if (pd_count >= pd_target) begin
                power_down <= 1'b1;
            end else begin
                pd_count <= pd_count + 28'h0000001;
            end
        end
    end
    // ----------------------------------------------------------------
    // APB register access
    // ----------------------------------------------------------------
    wire logic wr = psel && penable && pwrite && pready;
    wire logic rd_sel = psel && !penable;
    wire logic hit_cfg = paddr == `OFS_CONFIG;
    wire logic hit_pd = paddr == `OFS_POWER_DOWN;
    wire logic hit_si = paddr == `OFS_STEP_INTERVAL;
    wire logic hit_qp = paddr == `OFS_QUIET_PWM;
    wire logic hit_la = paddr == `OFS_LOAD_ADAPT;
    wire logic hit_hs = paddr == `OFS_HIGH_SPEED;
    wire logic hit_st = paddr == `OFS_STATUS;
    wire logic hit_ch = paddr == `OFS_CHOPPER;
    wire logic mapped = hit_cfg | hit_pd | hit_si | hit_qp | hit_la
        | hit_hs | hit_st | hit_ch;
    wire logic [31:0] status_word = {19'h00000, power_down, hold_current,
        stst_raw, fast_high, fast_load, fast_quiet, mode.fullstep,
        mode.pwm_chop, mode.stall_detect, mode.load_adapt,
        mode.stall_out, mode.velocity_step, pwm_on};
    wire logic [31:0] rd_mux =
          hit_cfg ? {27'h0000000, cfg.ext_step, cfg.en_pwm, cfg.hs_chopper,
                     cfg.hs_fullstep, cfg.small_hyst}
        : hit_pd ? {24'h000000, power_down_delay}
        : hit_si ? {12'h000, step_interval}
        : hit_qp ? {12'h000, quiet_pwm_threshold}
        : hit_la ? {12'h000, load_adapt_threshold}
        : hit_hs ? {12'h000, high_speed_threshold}
        : hit_st ? status_word
        : hit_ch ? {28'h0000000, off_time_eff}
        : 32'h00000000;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= rd_sel;
            pslverr <= rd_sel && !mapped;
            if (rd_sel) prdata <= pwrite ? 32'h00000000 : rd_mux;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= '0;
            power_down_delay <= `POWER_DOWN_RESET;
            quiet_pwm_threshold <= '0;
            load_adapt_threshold <= '0;
            high_speed_threshold <= `HIGH_SPEED_RESET;
        end else if (wr) begin
            if (hit_cfg) begin
                cfg.small_hyst <= pwdata[`CFG_SMALL_HYST];
                cfg.hs_fullstep <= pwdata[`CFG_HS_FULLSTEP];
                cfg.hs_chopper <= pwdata[`CFG_HS_CHOPPER];
                cfg.en_pwm <= pwdata[`CFG_EN_PWM];
                cfg.ext_step <= pwdata[`CFG_EXT_STEP];
            end
            if (hit_pd) power_down_delay <= pwdata[7:0];
            if (hit_qp) quiet_pwm_threshold <= pwdata[W-1:0];
            if (hit_la) load_adapt_threshold <= pwdata[W-1:0];
            if (hit_hs) high_speed_threshold <= pwdata[W-1:0];
        end
    end
    // Effective PWM enable: off at once, on only at standstill
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) pwm_on <= 1'b0;
        else if (!cfg.en_pwm) pwm_on <= 1'b0;
        else if (stst_raw) pwm_on <= 1'b1;
    end
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_hold_follows;
        @(posedge pclk) disable iff (!presetn)
        hold_current == $past(stst_raw);
    endproperty
    a_hold_follows: assert property (p_hold_follows)
        else $error("hold current not tracking standstill");
    property p_pwm_on_only_stst;
        @(posedge pclk) disable iff (!presetn)
        $rose(pwm_on) |-> $past(stst_raw);
    endproperty
    a_pwm_on_only_stst: assert property (p_pwm_on_only_stst)
        else $error("pwm enabled outside standstill");
    property p_sync_off_high;
        @(posedge pclk) disable iff (!presetn)
        fast_high |=> !mode.chopper_sync && !mode.pwm_chop
            && !mode.load_adapt;
    endproperty
    a_sync_off_high: assert property (p_sync_off_high)
        else $error("high speed modes wrong");
    property p_stall_out;
        @(posedge pclk) disable iff (!presetn)
        ##1 mode.stall_out == $past(fast_load);
    endproperty
    a_stall_out: assert property (p_stall_out)
        else $error("stall output mismatch");
    property p_mid;
        @(posedge pclk) disable iff (!presetn)
        (fast_load && !fast_high) |=> mode.stall_detect && !mode.pwm_chop;
    endproperty
    a_mid: assert property (p_mid)
        else $error("mid zone modes wrong");
    property p_fs_45;
        @(posedge pclk) disable iff (!presetn)
        (mode.fullstep != $past(mode.fullstep)) |-> $past(at_45deg);
    endproperty
    a_fs_45: assert property (p_fs_45)
        else $error("full step changed off 45 degrees");
    property p_chop_hs;
        @(posedge pclk) disable iff (!presetn)
        (fast_high && cfg.hs_chopper) |=> mode.chopper_mode
            && mode.fast_decay_zero;
    endproperty
    a_chop_hs: assert property (p_chop_hs)
        else $error("high speed chopper not selected");
    property p_sat;
        @(posedge pclk) disable iff (!presetn)
        stst_raw |-> step_interval == `INTERVAL_MAX;
    endproperty
    a_sat: assert property (p_sat)
        else $error("interval not saturated at standstill");
    property p_pd_after_stst;
        @(posedge pclk) disable iff (!presetn)
        power_down |-> standstill;
    endproperty
    a_pd_after_stst: assert property (p_pd_after_stst)
        else $error("power down without standstill");
    property p_vstep_quiet;
        @(posedge pclk) disable iff (!presetn)
        quiet_zone |=> !mode.velocity_step;
    endproperty
    a_vstep_quiet: assert property (p_vstep_quiet)
        else $error("velocity step active in quiet zone");
    property p_mid_adapt;
        @(posedge pclk) disable iff (!presetn)
        mid_zone |=> mode.load_adapt && mode.stall_out;
    endproperty
    a_mid_adapt: assert property (p_mid_adapt)
        else $error("load adapt missing in mid zone");
    property p_off_double;
        @(posedge pclk) disable iff (!presetn)
        (fast_high && cfg.hs_chopper && !off_time[3])
            |=> off_time_eff == ($past(off_time) << 1);
    endproperty
    a_off_double: assert property (p_off_double)
        else $error("off time not doubled");
    property p_step_clears;
        @(posedge pclk) disable iff (!presetn)
        step |=> !stst_raw;
    endproperty
    a_step_clears: assert property (p_step_clears)
        else $error("standstill kept after step");
    property p_pd_zero;
        @(posedge pclk) disable iff (!presetn)
        (stst_raw && power_down_delay == 8'h00) |=> power_down;
    endproperty
    a_pd_zero: assert property (p_pd_zero)
        else $error("power down delayed with zero setting");
    property p_pwm_cfg_off;
        @(posedge pclk) disable iff (!presetn)
        !cfg.en_pwm |=> !pwm_on;
    endproperty
    a_pwm_cfg_off: assert property (p_pwm_cfg_off)
        else $error("pwm kept on with enable clear");
    c_stst: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(standstill));
    c_fullstep: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(mode.fullstep));
    c_mid: cover property (@(posedge pclk) disable iff (!presetn)
        mode.stall_detect);
    c_pd: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(power_down));
    c_hs_both: cover property (@(posedge pclk) disable iff (!presetn)
        mode.chopper_mode && mode.fullstep);
endmodule // velocity_mode_selector
`default_nettype wire

// *** tb/step_source.sv ***
// Step pulse source standing in for the ramp generator and step pin
`timescale 1ns/1ps
`default_nettype none
module step_source (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Step period in clocks, zero stops the steps
    input wire logic [15:0] period,
    // Step outputs
    output logic int_step,
    output logic ext_step_pin
);
    logic [15:0] count;
    // ----------------------------------------------------------------
    // Pulse and square wave generation
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 16'h0000;
            int_step <= 1'b0;
            ext_step_pin <= 1'b0;
        end else if (period == 16'h0000) begin
            count <= 16'h0000;
            int_step <= 1'b0;
        end else if (count >= period - 16'h0001) begin
            count <= 16'h0000;
            int_step <= 1'b1;
            ext_step_pin <= 1'b1;
        end else begin
            count <= count + 16'h0001;
            int_step <= 1'b0;
            if (count == (period >> 1)) begin
                ext_step_pin <= 1'b0;
            end
        end
    end
endmodule // step_source
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking testbench for the velocity mode selector
`timescale 1ns/1ps
`default_nettype none
`include "vms_cfg.svh"
module testbench import vms_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, at_45deg;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic pready, pslverr, int_step, ext_step_pin, err;
    logic hold_current, power_down, standstill;
    logic [8:0] weight;
    logic [3:0] off_time, off_time_eff;
    logic [15:0] period;
    vms_mode_t mode;
    int n_mismatch, n_tests;
    localparam int STST = 4096;
    velocity_mode_selector #(.PD_UNIT(16), .STST_CYCLES(STST)) i_dut (
        .pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .int_step(int_step), .ext_step_pin(ext_step_pin),
        .ustep_weight(weight), .at_45deg(at_45deg), .off_time(off_time),
        .mode(mode), .off_time_eff(off_time_eff),
        .hold_current(hold_current), .power_down(power_down),
        .standstill(standstill));
    step_source i_src (.pclk(pclk), .presetn(presetn), .period(period),
        .int_step(int_step), .ext_step_pin(ext_step_pin));
    // ----------------------------------------------------------------
    // Bus and compare tasks
    // ----------------------------------------------------------------
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic ck(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rd_ck(input string nm, input logic [11:0] a,
        input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        ck(nm, e, q);
    endtask
    task automatic run_at(input logic [15:0] p);
        period <= p;
        repeat (3 * int'(p) + 8) @(posedge pclk);
    endtask
    task automatic end_of_test;
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        rd_ck("config", `OFS_CONFIG, 32'h0);
        rd_ck("power_down_delay", `OFS_POWER_DOWN, 32'h0a);
        rd_ck("step_interval", `OFS_STEP_INTERVAL, 32'h0);
        rd_ck("quiet_pwm", `OFS_QUIET_PWM, 32'h0);
        rd_ck("load_adapt", `OFS_LOAD_ADAPT, 32'h0);
        rd_ck("high_speed", `OFS_HIGH_SPEED, 32'h0);
        ck("standstill", 32'h0, 32'(standstill));
    endtask
    task automatic t_regs;
        apb(1'b1, `OFS_POWER_DOWN, 32'h1ff);
        rd_ck("power_down_delay", `OFS_POWER_DOWN, 32'hff);
        apb(1'b1, `OFS_STEP_INTERVAL, 32'h123);
        rd_ck("step_interval", `OFS_STEP_INTERVAL, 32'h0);
        apb(1'b1, `OFS_QUIET_PWM, 32'hfffff);
        rd_ck("quiet_pwm", `OFS_QUIET_PWM, 32'hfffff);
        apb(1'b0, 12'h020, 32'h0);
        ck("unmapped error", 32'h1, 32'(err));
        ck("unmapped data", 32'h0, q);
    endtask
    task automatic t_interval;
        run_at(16'd40);
        rd_ck("interval full", `OFS_STEP_INTERVAL, 32'd40);
        weight <= 9'd8;
        run_at(16'd40);
        rd_ck("interval scaled", `OFS_STEP_INTERVAL, 32'd5);
        weight <= 9'd1;
        apb(1'b1, `OFS_POWER_DOWN, 32'h4);
        period <= 16'h0000;
        repeat (STST - 48) @(posedge pclk);
        ck("standstill early", 32'h0, 32'(standstill));
        ck("hold_current run", 32'h0, 32'(hold_current));
        repeat (64) @(posedge pclk);
        rd_ck("interval sat", `OFS_STEP_INTERVAL, 32'hfffff);
        ck("standstill", 32'h1, 32'(standstill));
        ck("hold_current", 32'h1, 32'(hold_current));
        ck("power_down early", 32'h0, 32'(power_down));
        apb(1'b1, `OFS_CONFIG, 32'h8);
        repeat (50) @(posedge pclk);
        ck("power_down", 32'h1, 32'(power_down));
        ck("pwm_chop standstill", 32'h1, 32'(mode.pwm_chop));
        apb(1'b1, `OFS_CONFIG, 32'h10);
        run_at(16'd50);
        rd_ck("interval pin", `OFS_STEP_INTERVAL, 32'd50);
    endtask
    task automatic t_modes;
        apb(1'b1, `OFS_QUIET_PWM, 32'd1000);
        apb(1'b1, `OFS_LOAD_ADAPT, 32'd500);
        apb(1'b1, `OFS_HIGH_SPEED, 32'd200);
        apb(1'b1, `OFS_CONFIG, 32'h6);
        run_at(16'd1200);
        ck("velocity_step", 32'h0, 32'(mode.velocity_step));
        ck("stall_out slow", 32'h0, 32'(mode.stall_out));
        run_at(16'd300);
        ck("stall_detect", 32'h1, 32'(mode.stall_detect));
        ck("load_adapt", 32'h1, 32'(mode.load_adapt));
        ck("pwm_chop", 32'h0, 32'(mode.pwm_chop));
        ck("stall_out", 32'h1, 32'(mode.stall_out));
        ck("chopper_mode mid", 32'h0, 32'(mode.chopper_mode));
        run_at(16'd100);
        ck("load_adapt fast", 32'h0, 32'(mode.load_adapt));
        ck("chopper_sync", 32'h0, 32'(mode.chopper_sync));
        ck("chopper_mode", 32'h1, 32'(mode.chopper_mode));
        ck("fast_decay_zero", 32'h1, 32'(mode.fast_decay_zero));
        ck("off_time_double", 32'h1, 32'(mode.off_time_double));
        ck("off_time_eff", 32'd10, 32'(off_time_eff));
        ck("fullstep off 45", 32'h0, 32'(mode.fullstep));
        at_45deg <= 1'b1;
        repeat (4) @(posedge pclk);
        ck("fullstep", 32'h1, 32'(mode.fullstep));
        ck("both high bits", 32'h1, 32'(mode.chopper_mode));
        at_45deg <= 1'b0;
        run_at(16'd210);
        rd_ck("fast_high wide", `OFS_STATUS, 32'h000003c6);
        ck("fast_high kept", 32'h1, 32'(q[9]));
        run_at(16'd220);
        apb(1'b0, `OFS_STATUS, 32'h0);
        ck("fast_high left", 32'h0, 32'(q[9]));
        ck("fullstep held", 32'h1, 32'(mode.fullstep));
        apb(1'b1, `OFS_CONFIG, 32'h7);
        run_at(16'd100);
        run_at(16'd210);
        apb(1'b0, `OFS_STATUS, 32'h0);
        ck("fast_high small", 32'h0, 32'(q[9]));
    endtask
    // ----------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        n_mismatch = 0;
        n_tests = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        weight = 9'd1;
        at_45deg = 1'b0;
        off_time = 4'h5;
        period = 16'h0000;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset;
        t_regs;
        t_interval;
        t_modes;
        end_of_test;
    end
    initial begin
        repeat (90000) @(posedge pclk);
        n_mismatch++;
        end_of_test;
    end
endmodule // testbench
`default_nettype wire
